// file: shared/rsad_pkg.sv
// Constants and types for the register space address decoder
package rsad_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int REG_W = 11;
    localparam int PG_W = 4;

    // ********************************
    // Targets
    // ********************************
    typedef enum logic [4:0] {
        T_PORT, T_MMAP, T_DEVID, T_DBGCMP, T_CLKRST, T_TMR_A, T_ADC,
        T_PWM, T_UART_A, T_UART_B, T_SPI, T_TWI, T_FCTL, T_INTC,
        T_CAN_A, T_CAN_B, T_MOTOR, T_DISP, T_STALL_A, T_STALL_B,
        T_STALL_C, T_STALL_D, T_TMR_B, T_VREG,
        T_DATA_FLASH, T_RAM, T_PROG_FLASH
    } rsad_tgt_t;
    localparam int NTGT = int'(T_PROG_FLASH) + 1;

    // ********************************
    // Register page windows
    // ********************************
    typedef struct packed {
        logic [REG_W-1:0] lo;
        logic [REG_W-1:0] hi;
        rsad_tgt_t tgt;
    } rsad_win_t;

    localparam int NWIN = 28;
    localparam int W_PORT_HI = 22;
    localparam int W_ADC = 9;
    localparam int W_CAN_B = 18;
    localparam rsad_win_t WINS [NWIN] = '{
        '{11'h000, 11'h009, T_PORT},
        '{11'h00C, 11'h00D, T_PORT},
        '{11'h01C, 11'h01F, T_PORT},
        '{11'h00A, 11'h00B, T_MMAP},
        '{11'h010, 11'h017, T_MMAP},
        '{11'h01A, 11'h01B, T_DEVID},
        '{11'h020, 11'h02F, T_DBGCMP},
        '{11'h034, 11'h03F, T_CLKRST},
        '{11'h040, 11'h06F, T_TMR_A},
        '{11'h070, 11'h09F, T_ADC},
        '{11'h0A0, 11'h0C7, T_PWM},
        '{11'h0C8, 11'h0CF, T_UART_A},
        '{11'h0D0, 11'h0D7, T_UART_B},
        '{11'h0D8, 11'h0DF, T_SPI},
        '{11'h0E0, 11'h0E7, T_TWI},
        '{11'h100, 11'h113, T_FCTL},
        '{11'h120, 11'h12F, T_INTC},
        '{11'h140, 11'h17F, T_CAN_A},
        '{11'h180, 11'h1BF, T_CAN_B},
        '{11'h1C0, 11'h1FF, T_MOTOR},
        '{11'h200, 11'h21F, T_DISP},
        '{11'h220, 11'h227, T_STALL_A},
        '{11'h240, 11'h29F, T_PORT},
        '{11'h228, 11'h22F, T_STALL_B},
        '{11'h230, 11'h237, T_STALL_C},
        '{11'h238, 11'h23F, T_STALL_D},
        '{11'h2A0, 11'h2CF, T_TMR_B},
        '{11'h2F0, 11'h2F7, T_VREG}
    };

    // ********************************
    // Global map
    // ********************************
    localparam logic [ADDR_W-1:0] REG_TOP = 23'h0007FF;
    localparam logic [ADDR_W-1:0] UNDEF_LO = 23'h000C00;
    localparam logic [ADDR_W-1:0] UNDEF_HI = 23'h000FFF;
    localparam logic [ADDR_W-1:0] DF_LO = 23'h100000;
    localparam logic [ADDR_W-1:0] DF_HIGH = 23'h101FFF;
    localparam logic [ADDR_W-1:0] DF_WIN_HI = 23'h13FFFF;
    localparam logic [ADDR_W-1:0] RAM_LOW_L = 23'h0FD000;
    localparam logic [ADDR_W-1:0] RAM_LOW_S = 23'h0FE000;
    localparam logic [ADDR_W-1:0] RAM_TOP = 23'h0FFFFF;
    localparam logic [ADDR_W-1:0] FL_LOW_L = 23'h7C0000;
    localparam logic [ADDR_W-1:0] FL_LOW_S = 23'h7E0000;
    localparam logic [ADDR_W-1:0] FL_TOP = 23'h7FFFFF;
    localparam int DF_PG_LSB = 10;
    localparam int RAM_PG_LSB = 12;
    localparam int FL_PG_LSB = 14;
    localparam logic [PG_W-1:0] DF_PAGES = 4'h8;
    localparam logic [PG_W-1:0] RAM_PAGES_L = 4'h3;
    localparam logic [PG_W-1:0] RAM_PAGES_S = 4'h2;
    // One bit wider than a page index: sixteen pages do not fit in four bits
    localparam logic [PG_W:0] FL_PAGES_L = 5'h10;
    localparam logic [PG_W:0] FL_PAGES_S = 5'h08;

    // ********************************
    // Bus request
    // ********************************
    typedef struct packed {
        logic valid;
        logic write;
        logic background_debug_master;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rsad_req_t;

endpackage

// file: hw/rsad_decoder.sv
// Register page and global memory map address decoder
`timescale 1ns/1ps

module rsad_decoder
    import rsad_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire rsad_req_t req,
    input wire logic [DATA_W-1:0] periph_rdata,
    output logic [NTGT-1:0] sel_r,
    output logic rd_r,
    output logic wr_r,
    output logic [ADDR_W-1:0] addr_r,
    output logic [DATA_W-1:0] wdata_r,
    output logic [DATA_W-1:0] rdata_r,
    output logic [PG_W-1:0] page_r,
    output logic illegal_rst_r
);

    // ********************************
    // Variant constants
    // ********************************
    localparam logic [ADDR_W-1:0] RAM_LOW = LARGE ? RAM_LOW_L : RAM_LOW_S;
    localparam logic [ADDR_W-1:0] FL_LOW = LARGE ? FL_LOW_L : FL_LOW_S;
    localparam logic [PG_W-1:0] RAM_PAGES = LARGE ? RAM_PAGES_L : RAM_PAGES_S;
    localparam logic [PG_W:0] FL_PAGES = LARGE ? FL_PAGES_L : FL_PAGES_S;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ********************************
    // Register page decode
    // ********************************
    wire logic [ADDR_W-1:0] addr = req.addr;
    wire logic [REG_W-1:0] reg_off = addr[REG_W-1:0];
    wire logic in_reg = addr <= REG_TOP;
    logic [NWIN-1:0] win_hit;
    logic [NTGT-1:0] reg_sel;

    genvar w;
    generate
        for (w = 0; w < NWIN; w++) begin : g_win
            // One comparator pair per window
            assign win_hit[w] = in_reg && reg_off >= WINS[w].lo
                && reg_off <= WINS[w].hi;
        end
    endgenerate

    // Several windows share a target, so fold hits onto targets
    always_comb begin
        reg_sel = '0;
        for (int i = 0; i < NWIN; i++) begin
            if (win_hit[i]) begin
                reg_sel[WINS[i].tgt] = 1'b1;
            end
        end
    end

    // ********************************
    // Memory decode
    // ********************************
    wire logic undef = addr >= UNDEF_LO && addr <= UNDEF_HI;
    wire logic df_hit = addr >= DF_LO && addr <= DF_HIGH;
    wire logic ram_hit = addr >= RAM_LOW && addr <= RAM_TOP;
    wire logic fl_hit = addr >= FL_LOW && addr <= FL_TOP;
    // Data flash window beyond its last page has no cells behind it
    wire logic reg_rsvd = in_reg && !(|win_hit);
    wire logic unimpl = !(in_reg || undef || df_hit || ram_hit || fl_hit);

    wire logic [ADDR_W-1:0] df_off = addr - DF_LO;
    wire logic [ADDR_W-1:0] ram_off = addr - RAM_LOW;
    wire logic [ADDR_W-1:0] fl_off = addr - FL_LOW;

    logic [NTGT-1:0] dec;
    always_comb begin
        dec = reg_sel;
        dec[T_DATA_FLASH] = df_hit;
        dec[T_RAM] = ram_hit;
        dec[T_PROG_FLASH] = fl_hit;
    end

    // ********************************
    // Next values
    // ********************************
    wire logic rd_req = req.valid && !req.write;
    wire logic wr_req = req.valid && req.write;
    wire logic claimed = |dec;
    // Select only on a live access; ranges are disjoint
    wire logic [NTGT-1:0] sel_nxt = req.valid ? dec : '0;
    // Reserved writes reach nobody
    wire logic wr_nxt = wr_req && claimed;
    wire logic rd_nxt = rd_req && claimed;
    // Undefined area passes whatever the fabric returns
    wire logic zero_rd = reg_rsvd || unimpl;
    wire logic [DATA_W-1:0] rdata_nxt =
        (rd_req && !zero_rd) ? periph_rdata : '0;
    // Debug master accesses never reset the part
    wire logic illegal_nxt = req.valid && !req.background_debug_master && unimpl;

    wire logic [PG_W-1:0] df_pg =
        {1'b0, df_off[DF_PG_LSB+2:DF_PG_LSB]};
    wire logic [PG_W-1:0] ram_pg =
        {2'b00, ram_off[RAM_PG_LSB+1:RAM_PG_LSB]};
    wire logic [PG_W-1:0] fl_pg =
        fl_off[FL_PG_LSB+PG_W-1:FL_PG_LSB];
    wire logic [PG_W-1:0] page_nxt =
        !req.valid ? '0 :
        df_hit ? df_pg :
        ram_hit ? ram_pg :
        fl_hit ? fl_pg : '0;

    // ********************************
    // Output registers
    // ********************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_r <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            page_r <= '0;
            illegal_rst_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr;
            wdata_r <= req.wdata;
            rdata_r <= rdata_nxt;
            page_r <= page_nxt;
            illegal_rst_r <= illegal_nxt;
        end
    end

    // ********************************
    // Checks
    // ********************************
    // Table slots of the windows judged one by one below
    localparam int W_MMAP = 4;
    localparam int W_CLKRST = 7;
    localparam int W_PWM = 10;
    localparam int W_UART_B = 12;
    localparam int W_SPI = 13;
    localparam int W_TWI = 14;
    localparam int W_FCTL = 15;
    localparam int W_INTC = 16;
    localparam int W_MOTOR = 19;
    localparam int W_STALL_D = 25;
    localparam int W_TMR_B = 26;

    sequence s_cpu_unimpl;
        req.valid && !req.background_debug_master && unimpl;
    endsequence

    sequence s_no_access;
        sel_r == '0 && !rd_r && !wr_r;
    endsequence

    sequence s_rsvd_wr;
        wr_req && reg_rsvd;
    endsequence

    a_one_select: assert property (
        sel_r != '0 |-> $onehot(sel_r) && $past(req.valid))
        else $error("select not unique or without access");

    a_adc_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_ADC].lo
            && reg_off <= WINS[W_ADC].hi
        |=> sel_r[T_ADC] && (rd_r != wr_r))
        else $error("converter window not selected");

    a_port_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_PORT_HI].lo
            && reg_off <= WINS[W_PORT_HI].hi
        |=> sel_r[T_PORT] && addr_r == $past(addr))
        else $error("port window not selected");

    a_can_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_CAN_B].lo
            && reg_off <= WINS[W_CAN_B].hi
        |=> sel_r[T_CAN_B] && !sel_r[T_CAN_A])
        else $error("second CAN window not selected");

    a_rsvd_read: assert property (
        rd_req && reg_rsvd |=> rdata_r == '0 && !rd_r)
        else $error("reserved read not zero");

    a_rsvd_write: assert property (
        s_rsvd_wr |=> s_no_access)
        else $error("reserved write reached a target");

    a_undef_pass: assert property (
        rd_req && undef
        |=> rdata_r == $past(periph_rdata) && !illegal_rst_r)
        else $error("undefined area read mishandled");

    a_illegal_reset: assert property (
        s_cpu_unimpl |=> illegal_rst_r ##0 s_no_access)
        else $error("unimplemented access without reset");

    a_reset_cause: assert property (
        illegal_rst_r |-> $past(req.valid) && !$past(req.background_debug_master))
        else $error("reset without CPU access");

    a_reg_no_reset: assert property (
        req.valid && in_reg |=> !illegal_rst_r)
        else $error("register page access caused reset");

    a_data_flash_array_page: assert property (
        req.valid && df_hit |=> sel_r[T_DATA_FLASH] && page_r < DF_PAGES)
        else $error("data flash page out of range");

    a_data_flash_array_tail: assert property (
        req.valid && !req.background_debug_master && addr > DF_HIGH && addr <= DF_WIN_HI
        |=> illegal_rst_r ##0 s_no_access)
        else $error("data flash tail not unimplemented");

    a_ram_page: assert property (
        req.valid && ram_hit |=> sel_r[T_RAM] && page_r < RAM_PAGES)
        else $error("RAM page out of range");

    a_flash_page: assert property (
        req.valid && fl_hit |=> sel_r[T_PROG_FLASH] && {1'b0, page_r} < FL_PAGES)
        else $error("program flash page out of range");

    a_mmap_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_MMAP].lo
            && reg_off <= WINS[W_MMAP].hi
        |=> sel_r[T_MMAP] && $onehot(sel_r))
        else $error("memory map window not selected");

    a_clkrst_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_CLKRST].lo
            && reg_off <= WINS[W_CLKRST].hi
        |=> sel_r[T_CLKRST] && $onehot(sel_r))
        else $error("clock reset window not selected");

    a_pwm_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_PWM].lo
            && reg_off <= WINS[W_PWM].hi
        |=> sel_r[T_PWM] && $onehot(sel_r))
        else $error("modulator window not selected");

    a_timer_b_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_TMR_B].lo
            && reg_off <= WINS[W_TMR_B].hi
        |=> sel_r[T_TMR_B] && !sel_r[T_TMR_A])
        else $error("second timer window not selected");

    a_serial_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_UART_B].lo
            && reg_off <= WINS[W_UART_B].hi
        |=> sel_r[T_UART_B] && !sel_r[T_UART_A])
        else $error("second serial window not selected");

    a_spi_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_SPI].lo
            && reg_off <= WINS[W_SPI].hi
        |=> sel_r[T_SPI] && $onehot(sel_r))
        else $error("SPI window not selected");

    a_twi_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_TWI].lo
            && reg_off <= WINS[W_TWI].hi
        |=> sel_r[T_TWI] && $onehot(sel_r))
        else $error("two-wire window not selected");

    a_fctl_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_FCTL].lo
            && reg_off <= WINS[W_FCTL].hi
        |=> sel_r[T_FCTL] && $onehot(sel_r))
        else $error("flash controller window not selected");

    a_intc_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_INTC].lo
            && reg_off <= WINS[W_INTC].hi
        |=> sel_r[T_INTC] && $onehot(sel_r))
        else $error("interrupt window not selected");

    a_motor_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_MOTOR].lo
            && reg_off <= WINS[W_MOTOR].hi
        |=> sel_r[T_MOTOR] && $onehot(sel_r))
        else $error("motor window not selected");

    a_stall_window: assert property (
        req.valid && in_reg && reg_off >= WINS[W_STALL_D].lo
            && reg_off <= WINS[W_STALL_D].hi
        |=> sel_r[T_STALL_D] && !sel_r[T_STALL_C])
        else $error("fourth stall window not selected");

endmodule

// file: sim/rsad_master_model.sv
// Bus master model standing in for the processor and the debug master
`timescale 1ns/1ps
module rsad_master_model
    import rsad_pkg::*;
(
    input wire logic clk,
    output rsad_req_t req,
    output logic [DATA_W-1:0] periph_rdata
);
    // ********************************
    // Fabric and request
    // ********************************
    initial begin
        req = '0;
    end

    // Fabric read data follows the address, so a stale word shows up
    assign periph_rdata = req.addr[15:0] ^ 16'hA5C3;

    // One access per call; the bus idles at zero afterwards
    task automatic access(input logic wr, input logic dbg, input logic [ADDR_W-1:0] a);
        @(posedge clk);
        req <= '{valid: 1'b1, write: wr, background_debug_master: dbg, addr: a, wdata: ~a[15:0]};
        @(posedge clk);
        req <= '0;
    endtask
endmodule

// file: sim/rsad_decoder_tb_top.sv
// Self-checking bench for the register space address decoder
`timescale 1ns/1ps
module rsad_decoder_tb_top
    import rsad_pkg::*;
;
    // ********************************
    // Signals
    // ********************************
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    rsad_req_t req;
    logic [DATA_W-1:0] periph_rdata;
    logic [NTGT-1:0] sel_r;
    logic [NTGT-1:0] sel_s;
    logic rd_r;
    logic wr_r;
    logic illegal_rst_r;
    logic ill_s;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata_r;
    logic [PG_W-1:0] page_r;
    logic [PG_W-1:0] page_s;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    // Window low, high and target index
    localparam logic [31:0] TB_WIN [28] = '{
        32'h000_009_00, 32'h00C_00D_00, 32'h01C_01F_00, 32'h240_29F_00,
        32'h00A_00B_01, 32'h010_017_01, 32'h01A_01B_02,
        32'h020_02F_03, 32'h034_03F_04, 32'h040_06F_05,
        32'h070_09F_06,
        32'h0A0_0C7_07, 32'h2A0_2CF_16,
        32'h0C8_0CF_08, 32'h0D0_0D7_09,
        32'h0D8_0DF_0A, 32'h0E0_0E7_0B,
        32'h100_113_0C,
        32'h120_12F_0D,
        32'h140_17F_0E, 32'h180_1BF_0F,
        32'h1C0_1FF_10, 32'h200_21F_11,
        32'h220_227_12, 32'h228_22F_13, 32'h230_237_14, 32'h238_23F_15, 32'h2F0_2F7_17
    };
    localparam logic [31:0] TB_RSV [10] = '{32'h00E, 32'h018, 32'h030, 32'h0E8, 32'h0FF,
        32'h114, 32'h130, 32'h2D0, 32'h2F8, 32'h7FF};

    // ********************************
    // Clock, instances, timeout
    // ********************************
    always #12.5 clk = ~clk;

    rsad_master_model i_master (.clk(clk), .req(req), .periph_rdata(periph_rdata));

    rsad_decoder #(.LARGE(1'b1)) i_dut (.clk(clk), .reset_n(reset_n), .req(req),
        .periph_rdata(periph_rdata), .sel_r(sel_r), .rd_r(rd_r), .wr_r(wr_r), .addr_r(addr_r),
        .wdata_r(wdata_r), .rdata_r(rdata_r), .page_r(page_r), .illegal_rst_r(illegal_rst_r));

    // Small variant shares the bus; only its map is judged
    rsad_decoder #(.LARGE(1'b0)) i_dut_small (.clk(clk), .reset_n(reset_n), .req(req),
        .periph_rdata(periph_rdata), .sel_r(sel_s), .rd_r(), .wr_r(), .addr_r(), .wdata_r(),
        .rdata_r(), .page_r(page_s), .illegal_rst_r(ill_s));

    // About 124 accesses of two cycles each; generous ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            $display("[FAIL] %0t run did not finish", $time);
            test_done();
        end
    end

    // ********************************
    // Helpers
    // ********************************
    task automatic fail(input string msg);
        err_count++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    // Judge the registered answer in the one cycle it stands
    task automatic probe(input logic wr, input logic dbg, input logic [ADDR_W-1:0] a,
                         input int tgt, input logic ill, input logic [PG_W-1:0] pg);
        logic [NTGT-1:0] exp_sel;
        logic [DATA_W-1:0] exp_rd;
        exp_sel = (tgt < 0) ? '0 : (NTGT'(1) << tgt);
        exp_rd = (tgt >= 0 && !wr) ? (a[15:0] ^ 16'hA5C3) : 16'h0000;
        i_master.access(wr, dbg, a);
        #1;
        check_count++;
        if (sel_r !== exp_sel || rd_r !== (tgt >= 0 && !wr) || wr_r !== (tgt >= 0 && wr)
            || illegal_rst_r !== ill || page_r !== pg || addr_r !== a
            || (wr && wdata_r !== ~a[15:0]) || (a[ADDR_W-1:10] != 'h3 && rdata_r !== exp_rd))
            fail($sformatf("addr %h answer wrong", a));
    endtask

    task automatic probe_s(input logic [ADDR_W-1:0] a, input int tgt, input logic ill,
                           input logic [PG_W-1:0] pg);
        i_master.access(1'b0, 1'b0, a);
        #1;
        check_count++;
        if (sel_s !== ((tgt < 0) ? '0 : (NTGT'(1) << tgt)) || ill_s !== ill || page_s !== pg)
            fail($sformatf("small variant addr %h wrong", a));
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_windows();
        foreach (TB_WIN[i]) begin
            probe(1'b0, 1'b0, ADDR_W'(TB_WIN[i][31:20]), int'(TB_WIN[i][7:0]),
                1'b0, 4'h0);
            probe(1'b0, 1'b1, ADDR_W'(TB_WIN[i][19:8]), int'(TB_WIN[i][7:0]),
                1'b0, 4'h0);
            probe(1'b1, 1'b0, ADDR_W'(TB_WIN[i][19:8]), int'(TB_WIN[i][7:0]),
                1'b0, 4'h0);
        end
        @(posedge clk);
        #1;
        check_count++;
        if (sel_r !== '0 || rd_r !== 1'b0 || wr_r !== 1'b0)
            fail("select outlived its access");
    endtask

    task automatic t_reserved();
        foreach (TB_RSV[i]) begin
            probe(1'b0, 1'b0, TB_RSV[i][22:0], -1, 1'b0, 4'h0);
            probe(1'b1, 1'b0, TB_RSV[i][22:0], -1, 1'b0, 4'h0);
        end
    endtask

    task automatic t_undefined();
        probe(1'b0, 1'b0, 23'h000C00, -1, 1'b0, 4'h0);
        probe(1'b0, 1'b0, 23'h000FFF, -1, 1'b0, 4'h0);
    endtask

    task automatic t_unimpl();
        probe(1'b0, 1'b0, 23'h000800, -1, 1'b1, 4'h0);
        probe(1'b1, 1'b0, 23'h200000, -1, 1'b1, 4'h0);
        probe(1'b0, 1'b1, 23'h200000, -1, 1'b0, 4'h0);
        probe(1'b0, 1'b0, 23'h102000, -1, 1'b1, 4'h0);
    endtask

    task automatic t_memory();
        probe(1'b0, 1'b0, 23'h100000, int'(T_DATA_FLASH), 1'b0, 4'h0);
        probe(1'b0, 1'b0, 23'h101FFF, int'(T_DATA_FLASH), 1'b0, 4'h7);
        probe(1'b0, 1'b0, 23'h0FCFFF, -1, 1'b1, 4'h0);
        probe(1'b0, 1'b0, 23'h0FD000, int'(T_RAM), 1'b0, 4'h0);
        probe(1'b0, 1'b0, 23'h0FFFFF, int'(T_RAM), 1'b0, 4'h2);
        probe(1'b0, 1'b0, 23'h7BFFFF, -1, 1'b1, 4'h0);
        probe(1'b0, 1'b0, 23'h7C0000, int'(T_PROG_FLASH), 1'b0, 4'h0);
        probe(1'b0, 1'b0, 23'h7FFFFF, int'(T_PROG_FLASH), 1'b0, 4'hF);
    endtask

    task automatic t_small();
        probe_s(23'h0FDFFF, -1, 1'b1, 4'h0);
        probe_s(23'h0FE000, int'(T_RAM), 1'b0, 4'h0);
        probe_s(23'h0FFFFF, int'(T_RAM), 1'b0, 4'h1);
        probe_s(23'h7DFFFF, -1, 1'b1, 4'h0);
        probe_s(23'h7E0000, int'(T_PROG_FLASH), 1'b0, 4'h0);
        probe_s(23'h7FFFFF, int'(T_PROG_FLASH), 1'b0, 4'h7);
    endtask

    task automatic test_done();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_windows();
        t_reserved();
        t_undefined();
        t_unimpl();
        t_memory();
        t_small();
        test_done();
    end
endmodule
